/* File: inc/hbid_pkg.sv */
// Constants for the host-bridge identification and command registers.
// Assumes dword-wide configuration accesses through the data window.
package hbid_pkg;
  localparam logic [15:0] HBID_CFG_DATA_PORT  = 16'h0CFC;
  localparam int          HBID_CFG_ENABLE_BIT = 31;
  localparam logic [7:0]  HBID_BUS_NUM        = 8'h00;
  localparam logic [4:0]  HBID_DEV_NUM        = 5'h00;
  localparam logic [2:0]  HBID_FUNC_NUM       = 3'h0;

  // Register byte offsets within the function
  localparam logic [7:0]  HBID_VENDOR_CODE_OFS     = 8'h00;
  localparam logic [7:0]  HBID_DEVICE_CODE_OFS     = 8'h02;
  localparam logic [7:0]  HBID_COMMAND_CONTROL_OFS = 8'h04;
  localparam logic [7:0]  HBID_STATUS_FLAGS_OFS    = 8'h06;
  // Dword register numbers (address bits 7:2)
  localparam logic [5:0]  HBID_REGNUM_ID   = 6'h00;
  localparam logic [5:0]  HBID_REGNUM_CMD  = 6'h01;

  // Command field positions and reset value
  localparam logic [15:0] HBID_CMD_RESET      = 16'h0006;
  localparam int          HBID_CMD_PERR_BIT   = 6;
  localparam int          HBID_CMD_STEP_BIT   = 7;
  localparam int          HBID_CMD_SERR_BIT   = 8;
  localparam int          HBID_CMD_FAST_BACK_TO_BACK_ENABLE_BIT   = 9;
  // Status: fixed bits and detected-parity position
  localparam logic [15:0] HBID_STS_FIXED      = 16'h0090;
  localparam int          HBID_STS_DPE_BIT    = 15;
  localparam logic        HBID_FLAG_RESET     = 1'b0;
endpackage

/* File: rtl/hbid_regs.sv */
// Identification and command registers of the host-bridge function.
// Assumes configuration address register contents are presented on
// cfg_addr_in while a window access strobe is high; one access per cycle.

module hbid_regs
  import hbid_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = 16'h1A2B, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h3C4D, // Arbitrary value
  parameter int          NUM_EXT_DEV = 3
) (
  input  wire logic                   clk_in,          // Core clock
  input  wire logic                   resetn_in,       // Sync reset, low
  input  wire logic [31:0]            cfg_addr_in,     // Config address reg
  input  wire logic [15:0]            io_addr_in,      // I/O port address
  input  wire logic                   io_read_in,      // I/O read strobe
  input  wire logic                   io_write_in,     // I/O write strobe
  input  wire logic [3:0]             io_byte_en_in,   // Byte enables
  input  wire logic [31:0]            io_wdata_in,     // Write data
  input  wire logic                   parity_error_in, // Hub link parity err
  input  wire logic [NUM_EXT_DEV-1:0] ext_serr_en_in,  // Devices 2-4 enables
  input  wire logic [NUM_EXT_DEV-1:0] ext_error_in,    // Devices 2-4 errors
  output logic [31:0]                 rdata_out,       // Read data
  output logic                        rdata_valid_out, // Read answer pulse
  output logic                        serr_msg_out,    // Hub link message
  output logic                        serr_mech_en_out,// Messaging enabled
  output logic                        dpe_flag_out     // Detected parity
);

  if (NUM_EXT_DEV < 1 || NUM_EXT_DEV > 8) begin : g_chk
    $error("NUM_EXT_DEV out of range");
  end

  // Command fields must sit inside the 16-bit register
  if (HBID_CMD_PERR_BIT > 15 || HBID_CMD_STEP_BIT > 15
      || HBID_CMD_SERR_BIT > 15 || HBID_CMD_FAST_BACK_TO_BACK_ENABLE_BIT > 15) begin : g_pos
    $error("Command field position out of range");
  end

  // Flag clear is taken from the upper half of the write word
  if (HBID_STS_DPE_BIT > 15) begin : g_sts
    $error("Status flag position out of range");
  end

  // Reserved command bits must come out of reset as zero
  if (HBID_CMD_RESET[15:10] != 6'h00) begin : g_rst
    $error("Command reset value sets reserved bits");
  end

  logic        perr_en_reg;
  logic        serr_en_reg;
  logic        dpe_reg;
  logic [15:0] cmd_value;
  logic [15:0] sts_value;
  logic        hit;
  logic        wr_cmd;
  logic        ext_req;
  logic        dev0_event;

  // Decoded address fields and derived strobes
  logic        cfg_enable;
  logic [7:0]  cfg_bus;
  logic [4:0]  cfg_dev;
  logic [2:0]  cfg_func;
  logic [5:0]  cfg_regnum;
  logic        rd_hit;
  logic        wr_perr;
  logic        wr_serr;
  logic        clr_dpe;
  logic        dev0_serr;
  logic [31:0] read_word;
  logic [31:0] rdata_reg;
  logic        rdata_valid_reg;
  logic        serr_msg_reg;
  logic        serr_mech_en_reg;
  wire logic [NUM_EXT_DEV-1:0] ext_gate;

  // Decode: window port, enable bit, bus 0 device 0 function 0
  assign cfg_enable = cfg_addr_in[HBID_CFG_ENABLE_BIT];
  assign cfg_bus    = cfg_addr_in[23:16];
  assign cfg_dev    = cfg_addr_in[15:11];
  assign cfg_func   = cfg_addr_in[10:8];
  assign cfg_regnum = cfg_addr_in[7:2];
  assign hit = cfg_enable
             && (io_addr_in == HBID_CFG_DATA_PORT)
             && (cfg_bus == HBID_BUS_NUM)
             && (cfg_dev == HBID_DEV_NUM)
             && (cfg_func == HBID_FUNC_NUM);
  assign wr_cmd = hit && io_write_in
               && (cfg_regnum == HBID_REGNUM_CMD);

  // Per-field write strobes; other written bits are dropped
  assign rd_hit     = hit && io_read_in;
  assign wr_perr    = wr_cmd && io_byte_en_in[HBID_CMD_PERR_BIT / 8];
  assign wr_serr    = wr_cmd && io_byte_en_in[HBID_CMD_SERR_BIT / 8];
  assign clr_dpe    = wr_cmd && io_byte_en_in[2 + HBID_STS_DPE_BIT / 8]
                   && io_wdata_in[16 + HBID_STS_DPE_BIT];

  // Command word: fixed bits from the reset value, two stored enables
  always_comb begin
    cmd_value = HBID_CMD_RESET;
    cmd_value[HBID_CMD_PERR_BIT] = perr_en_reg;
    cmd_value[HBID_CMD_STEP_BIT] = 1'b0;
    cmd_value[HBID_CMD_SERR_BIT] = serr_en_reg;
    cmd_value[HBID_CMD_FAST_BACK_TO_BACK_ENABLE_BIT] = 1'b0;
  end

  // Status word: fixed bits plus the detected-parity flag
  always_comb begin
    sts_value = HBID_STS_FIXED;
    sts_value[HBID_STS_DPE_BIT] = dpe_reg;
  end

  // Parity-response enable; hardwired bits are never stored
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      perr_en_reg <= HBID_CMD_RESET[HBID_CMD_PERR_BIT];
    end else if (wr_perr) begin
      perr_en_reg <= io_wdata_in[HBID_CMD_PERR_BIT];
    end
  end

  // System-error enable of this function only
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      serr_en_reg <= HBID_CMD_RESET[HBID_CMD_SERR_BIT];
    end else if (wr_serr) begin
      serr_en_reg <= io_wdata_in[HBID_CMD_SERR_BIT];
    end
  end

  assign dev0_event = parity_error_in && perr_en_reg;
  assign dev0_serr  = dev0_event && serr_en_reg;

  // Each further device is gated by its own enable only
  for (genvar i = 0; i < NUM_EXT_DEV; i++) begin : g_ext
    assign ext_gate[i] = ext_serr_en_in[i] && ext_error_in[i];
  end
  assign ext_req = |ext_gate;

  // Detected parity: write one to clear, new event wins
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      dpe_reg <= HBID_FLAG_RESET;
    end else if (dev0_event) begin
      dpe_reg <= 1'b1;
    end else if (clr_dpe) begin
      dpe_reg <= 1'b0;
    end
  end

  // System-error message toward the I/O hub, one pulse per cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      serr_msg_reg <= 1'b0;
    end else begin
      serr_msg_reg <= dev0_serr || ext_req;
    end
  end

  // Messaging mechanism enabled by any device's enable
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      serr_mech_en_reg <= 1'b0;
    end else begin
      serr_mech_en_reg <= serr_en_reg || (|ext_serr_en_in);
    end
  end

  // Read word selected by register number; identity is constant
  always_comb begin
    case (cfg_regnum)
      HBID_REGNUM_ID: begin
        read_word = {DEVICE_CODE, VENDOR_CODE};
      end
      HBID_REGNUM_CMD: begin
        read_word = {sts_value, cmd_value};
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // Answer pulse one cycle after a claimed read
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_valid_reg <= 1'b0;
    end else begin
      rdata_valid_reg <= rd_hit;
    end
  end

  // Read data holds until the next claimed read
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_hit) begin
      rdata_reg <= read_word;
    end
  end

  // Outputs straight from their flip-flops
  assign rdata_out        = rdata_reg;
  assign rdata_valid_out  = rdata_valid_reg;
  assign serr_msg_out     = serr_msg_reg;
  assign serr_mech_en_out = serr_mech_en_reg;
  assign dpe_flag_out     = dpe_reg;

endmodule

/* File: sim/hbid_sva.sv */
// Checker on the ports of the identification and command registers.
// Assumes one clock domain and the design's synchronous active-low reset.
module hbid_sva #(
  parameter int NUM_EXT_DEV = 3
) (
  input wire logic clk_in, resetn_in, io_read_in, io_write_in,
  input wire logic parity_error_in, rdata_valid_out, serr_msg_out,
  input wire logic serr_mech_en_out, dpe_flag_out,
  input wire logic [31:0] cfg_addr_in, io_wdata_in, rdata_out,
  input wire logic [15:0] io_addr_in,
  input wire logic [3:0] io_byte_en_in,
  input wire logic [NUM_EXT_DEV-1:0] ext_serr_en_in, ext_error_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire logic hit = io_addr_in == 16'h0CFC && cfg_addr_in[31] &&
                   cfg_addr_in[23:8] == 16'h0000;
  rd_valid_a: assert property (hit && io_read_in |=> rdata_valid_out)
    else $error("hit read got no answer");
  no_stray_a: assert property (
    !(hit && io_read_in) |=> !rdata_valid_out)
    else $error("answer without hit read");
  cmd_fixed_a: assert property (
    hit && io_read_in && cfg_addr_in[7:2] == 6'h01
    |=> (rdata_out[15:0] & 16'hFEBF) == 16'h0006)
    else $error("command fixed bits wrong");
  flag_cause_a: assert property (
    $rose(dpe_flag_out) |-> $past(parity_error_in))
    else $error("flag set without parity error");
  msg_cause_a: assert property (
    serr_msg_out |-> $past(parity_error_in)
    || $past(|(ext_error_in & ext_serr_en_in)))
    else $error("message without cause");
  ext_msg_a: assert property (
    |(ext_error_in & ext_serr_en_in) |=> serr_msg_out)
    else $error("enabled device error sent no message");
  mech_en_a: assert property (|ext_serr_en_in |=> serr_mech_en_out)
    else $error("messaging not enabled");
  flag_hold_a: assert property (
    dpe_flag_out && !(hit && io_write_in) |=> dpe_flag_out)
    else $error("flag lost without write");
endmodule
bind hbid_regs hbid_sva #(.NUM_EXT_DEV(NUM_EXT_DEV)) sva_u (
  .clk_in, .resetn_in, .io_read_in, .io_write_in, .parity_error_in,
  .rdata_valid_out, .serr_msg_out, .serr_mech_en_out, .dpe_flag_out,
  .cfg_addr_in, .io_wdata_in, .rdata_out, .io_addr_in, .io_byte_en_in,
  .ext_serr_en_in, .ext_error_in);

/* File: sim/hbid_hub_model.sv */
// Far end of hub link A: raises parity and device error events.
// Assumes events are launched on falling edges, one cycle wide.
module hbid_hub_model (
  input  wire logic       clk_in,           // Core clock
  output logic            parity_error_out, // Parity error event
  output logic [2:0]      ext_error_out     // Device 2-4 error events
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {parity_error_out, ext_error_out} = 4'h0;
  task automatic pulse(input logic p, input logic [2:0] e);
    @(negedge clk_in) {parity_error_out, ext_error_out} = {p, e};
    @(negedge clk_in) {parity_error_out, ext_error_out} = 4'h0;
  endtask
endmodule

/* File: sim/tb_top.sv */
// Bench for the identification and command registers.
// Assumes the hub model drives the hub link events.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, resetn_in = 0, io_read_in = 0, io_write_in = 0;
  logic parity_error_in, rdata_valid_out, serr_msg_out, serr_mech_en_out;
  logic dpe_flag_out;
  logic [31:0] cfg_addr_in = 0, io_wdata_in = 0, rdata_out;
  logic [15:0] io_addr_in = 16'h0CFC;
  logic [3:0] io_byte_en_in = 0;
  logic [2:0] ext_serr_en_in = 0, ext_error_in;
  int num_errors = 0, check_count = 0, lfsr = 990, b6 = 0, b8 = 0, flg = 0;
  always #2.5 clk_in = ~clk_in;
  hbid_regs dut_u (.clk_in, .resetn_in, .cfg_addr_in, .io_addr_in, .io_read_in,
    .io_write_in, .io_byte_en_in, .io_wdata_in, .parity_error_in,
    .ext_serr_en_in, .ext_error_in, .rdata_out, .rdata_valid_out,
    .serr_msg_out, .serr_mech_en_out, .dpe_flag_out);
  hbid_hub_model hub_u (.clk_in, .parity_error_out(parity_error_in),
    .ext_error_out(ext_error_in));
  function automatic int nxt(int s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] ca, input logic [3:0] be,
                     input logic [31:0] d);
    @(negedge clk_in) {cfg_addr_in, io_read_in, io_write_in} = {ca, !w, w};
    {io_byte_en_in, io_wdata_in} = {be, d};
    @(negedge clk_in) {io_read_in, io_write_in} = 2'b00;
  endtask
  task automatic rd(input logic [5:0] r, input logic [31:0] exp);
    acc(0, {1'b1, 23'h0, r, 2'b00}, 4'hF, 0);
    chk({31'h0, rdata_valid_out}, 1);
    chk(rdata_out, exp);
  endtask
  task automatic wcmd(input logic [3:0] be, input logic [31:0] d);
    acc(1, 32'h8000_0004, be, d);
    if (be[0]) b6 = d[6];
    if (be[1]) b8 = d[8];
    if (be[3] && d[31]) flg = 0;
    rd(1, {16'h0090 | 16'(flg << 15),
           16'h0006 | 16'(b6 << 6 | b8 << 8)});
  endtask
  task automatic ev(input logic p, input logic [2:0] e);
    hub_u.pulse(p, e);
    if (p && b6) flg = 1;
    chk({31'h0, dpe_flag_out}, flg);
    chk({31'h0, serr_msg_out},
        p && b6 && b8 || |(e & ext_serr_en_in));
    chk({31'h0, serr_mech_en_out}, b8 || |ext_serr_en_in);
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    @(negedge clk_in) resetn_in = 1;
    rd(0, 32'h3C4D_1A2B);
    wcmd(4'h0, 0);
    ev(1, 0);
    acc(1, 32'h8000_0000, 4'hF, nxt(lfsr));
    rd(0, 32'h3C4D_1A2B);
    wcmd(4'h3, 32'hFFFF_FFFF);
    ev(1, 0);
    wcmd(4'hF, 32'h8000_0040);
    ev(1, 0);
    acc(0, 32'h0000_0004, 4'hF, 0);
    chk({31'h0, rdata_valid_out}, 0);
    io_addr_in = 16'h0CF8;
    acc(0, 32'h8000_0004, 4'hF, 0);
    chk({31'h0, rdata_valid_out}, 0);
    io_addr_in = 16'h0CFC;
    rd(2, 0);
    repeat (4) begin
      lfsr = nxt(lfsr);
      ext_serr_en_in = lfsr[2:0];
      ev(0, 3'h7);
    end
    close_out();
  end
  initial begin
    #20000;
    num_errors++;
    close_out();
  end
endmodule
